// ==== rtl/eft_regs.vh ====
// register map, field positions, reset values, trip codes and timing
`ifndef EFT_REGS_VH
`define EFT_REGS_VH

// byte offsets of the register words
`define EFT_OFS_CTRL       8'h00
`define EFT_OFS_STATUS     8'h04
`define EFT_OFS_IRQ_STAT   8'h08
`define EFT_OFS_IRQ_MASK   8'h0c
`define EFT_OFS_POSITION   8'h10
`define EFT_OFS_AUTOCFG    8'h14

// control word fields
`define EFT_CTRL_LVL_LSB   0
`define EFT_CTRL_AUTOCFG   4
`define EFT_CTRL_ABS_DIR   5
`define EFT_CTRL_TYPE_LSB  6
`define EFT_CTRL_REINIT    8

// error detection level bits
`define EFT_LVL_WIRE       0
`define EFT_LVL_PHASE      1
`define EFT_LVL_SUPPLY     2
`define EFT_LVL_SUPPRESS   3

// reset values
`define EFT_RST_LVL        4'h0
`define EFT_RST_AUTOCFG    1'h0
`define EFT_RST_TYPE       2'h0
`define EFT_RST_MASK       4'h0

// encoder types
`define EFT_TYPE_SSI       2'h0
`define EFT_TYPE_ASYNC     2'h1
`define EFT_TYPE_BIDIR     2'h2
`define EFT_TYPE_COMMS     2'h3

// trip numbers
`define EFT_TRIP_WIRE      5'h01
`define EFT_TRIP_PHASE     5'h02
`define EFT_TRIP_OVERLOAD  5'h03
`define EFT_TRIP_SUPPLY    5'h04
`define EFT_TRIP_FRAME     5'h05
`define EFT_TRIP_LAST_RUN  5'h06
`define EFT_TRIP_CFG_COMMS 5'h07
`define EFT_TRIP_CFG_UNREC 5'h0c
`define EFT_TRIP_CFG_RES   5'h0d
`define EFT_TRIP_CFG_LPR   5'h0f

// link frame layout
`define EFT_FRAME_BITS     6'h20
`define EFT_LPR_MAX        16'hc350

// timing
`define EFT_CLK_MHZ        100
`define EFT_INIT_TMO_US    20
`define EFT_INIT_TMO_CYC   (`EFT_INIT_TMO_US * `EFT_CLK_MHZ)

`endif

// ==== rtl/eft_sync3.v ====
`timescale 1ns/1ps
// three-stage input synchroniser; output follows once stages two and three agree
module eft_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;  // metastable stage, read by s2_r only
  reg [W-1:0] s2_r;  // second stage
  reg [W-1:0] s3_r;  // third stage
  reg [W-1:0] q_r;   // accepted value

  // shift chain
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: take the new level only when two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!rst_n) begin
          q_r[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  assign q = q_r;
endmodule

// ==== rtl/eft_encoder_trip.v ====
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "eft_regs.vh"
//
// Summary of operation
// R01: level bits enable wire, phase, supply checks
// R02: bit three suppresses trips 1-6 if not feedback
// R03: suppressed faults still handled, supply cut locally
// R04: suppressed fault sets freeze flag, records trip
// R05: drive reset clears freeze flag and trip
// R06: absolute mode recovers once noise stops
// R07: delta mode turns error persists until reinit
// R08: supply trip held until power, reset reinitialises
// R09: operator reinits after late encoder power-up
// R10: power-up interrogation sets turns, lines, resolution
// R11: sincos serial types also set rotary select
// R12: unknown, comms error, range raise 7/12-16
// R13: lines must exceed nine times motor poles; no pole check, code only rejects id_lpr of zero or above EFT_LPR_MAX
// R14: serial position type, bit selects binary decode
// R15: unsuppressed fault holds trip until drive reset
//
module eft_encoder_trip #(
  parameter [15:0] ID_KNOWN = 16'h00fe,  // recognised identity codes, arbitrary
  parameter        TMO_CYC  = `EFT_INIT_TMO_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        enc_clk,
  input  wire        enc_data,
  input  wire        enc_frame,
  input  wire        wire_break,
  input  wire        phase_error,
  input  wire        psu_overload,
  input  wire        drive_reset,
  input  wire        fb_selects_slot,
  output wire        slot_trip_request,
  output wire        freeze_position,
  output wire        psu_enable,
  output wire        irq
);
  // state codes of the init sequencer
  localparam [2:0] ST_IDLE = 3'h0;  // waiting for a start
  localparam [2:0] ST_ID   = 3'h1;  // waiting for identity frame
  localparam [2:0] ST_ABS  = 3'h2;  // waiting for first position frame
  localparam [2:0] ST_RUN  = 3'h3;  // tracking position
  localparam [2:0] ST_FAIL = 3'h4;  // config trip, wait for drive reset

  // synchronised pins
  wire [5:0] pin_s;
  wire       eclk_s;
  wire       edat_s;
  wire       efrm_s;
  wire       wire_s;
  wire       phase_s;
  wire       ovl_s;

  eft_sync3 #(
    .W (6)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({psu_overload, phase_error, wire_break, enc_frame, enc_data, enc_clk}),
    .q     (pin_s)
  );

  assign eclk_s  = pin_s[0];
  assign edat_s  = pin_s[1];
  assign efrm_s  = pin_s[2];
  assign wire_s  = pin_s[3];
  assign phase_s = pin_s[4];
  assign ovl_s   = pin_s[5];

  // software registers
  reg  [3:0]  lvl_r;        // error detection level
  reg         autocfg_r;    // auto-config / binary format select
  reg         abs_dir_r;    // take absolute position every frame
  reg  [1:0]  type_r;       // encoder type
  reg  [3:0]  irq_stat_r;   // sticky events
  reg  [3:0]  irq_mask_r;   // event enables
  reg         ack_r;        // bus answer phase
  reg  [31:0] rdata_r;      // read data
  // block state
  reg  [2:0]  st_r;
  reg         start_r;      // init pending
  reg  [15:0] tmo_r;        // init timeout counter
  reg         trip_r;       // drive trip request
  reg         freeze_r;     // suppressed trip flag
  reg  [4:0]  trip_num_r;   // last trip number
  reg         psu_en_r;     // encoder supply switch
  reg         pwr_ok_r;     // encoder reports power good
  reg  [15:0] lpr_r;        // equivalent lines per revolution
  reg  [4:0]  res_r;        // comms resolution
  reg  [3:0]  turns_bits_r; // turns bits in message
  reg         rotary_r;     // rotary (1) or linear (0)
  reg  [31:0] pos_r;        // turns:position
  reg  [15:0] last_r;       // last single-turn sample
  // link receiver
  reg         eclk_d_r;
  reg         efrm_d_r;
  reg  [31:0] sh_r;
  reg  [5:0]  cnt_r;

  // bus strobes
  wire        req    = avs_read | avs_write;
  wire        wr_acc = avs_write & ack_r;
  wire        be0    = avs_byteenable[0];
  wire        be1    = avs_byteenable[1];

  // link edges and frame completion
  wire        eclk_rise = eclk_s & ~eclk_d_r;
  wire        frm_end   = efrm_d_r & ~efrm_s;
  wire        frm_ok    = frm_end & (cnt_r == `EFT_FRAME_BITS);
  wire        frm_bad   = frm_end & (cnt_r != `EFT_FRAME_BITS);

  // answer one cycle after the request appears
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  // gray to binary over the position field
  function [29:0] gray2bin;
    input [29:0] g;
    integer k;
    begin
      gray2bin[29] = g[29];
      for (k = 28; k >= 0; k = k - 1) begin
        gray2bin[k] = gray2bin[k+1] ^ g[k];
      end
    end
  endfunction

  // plain ssi frames are gray unless the select bit asks for binary
  wire        use_bin = (type_r != `EFT_TYPE_SSI) | autocfg_r;  // [R14]
  wire [29:0] pos_dec = use_bin ? sh_r[29:0] : gray2bin(sh_r[29:0]);  // [R14]
  wire [15:0] delta   = pos_dec[15:0] - last_r;

  // identity frame fields
  wire [3:0]  id_code = sh_r[31:28];
  wire [15:0] id_lpr  = sh_r[23:8];
  wire [4:0]  id_res  = sh_r[7:3];
  wire        id_known = ID_KNOWN[id_code];

  // running faults, lowest number wins
  wire        run_on = (st_r != ST_IDLE);
  wire        f_wire = lvl_r[`EFT_LVL_WIRE] & wire_s;                     // [R01]
  wire        f_phs  = lvl_r[`EFT_LVL_PHASE] & phase_s;                   // [R01]
  wire        f_sup  = lvl_r[`EFT_LVL_SUPPLY] & ~pwr_ok_r & run_on;       // [R01] [R08]
  wire        f_frm  = frm_bad & (st_r == ST_RUN);
  reg  [4:0]  run_num;

  always @* begin
    if (f_wire) begin
      run_num = `EFT_TRIP_WIRE;
    end else if (f_phs) begin
      run_num = `EFT_TRIP_PHASE;
    end else if (ovl_s) begin
      run_num = `EFT_TRIP_OVERLOAD;
    end else if (f_sup) begin
      run_num = `EFT_TRIP_SUPPLY;
    end else if (f_frm) begin
      run_num = `EFT_TRIP_FRAME;
    end else begin
      run_num = 5'h00;
    end
  end

  // suppression applies only to running trips and only when not feedback
  wire        suppress = lvl_r[`EFT_LVL_SUPPRESS] & ~fb_selects_slot;  // [R02]

  // auto-config outcome, computed while in ST_ID; comms trip also in ST_ABS
  wire        cfg_active = autocfg_r & (type_r != `EFT_TYPE_SSI);  // [R10]
  reg  [4:0]  cfg_num;

  always @* begin
    cfg_num = 5'h00;
    if (st_r == ST_ID) begin
      if (tmo_r == 16'h0000 || frm_bad) begin
        cfg_num = `EFT_TRIP_CFG_COMMS;  // [R12]
      end else if (frm_ok && cfg_active) begin
        if (!id_known) begin
          cfg_num = `EFT_TRIP_CFG_UNREC;  // [R12]
        end else if (id_res == 5'h00) begin
          cfg_num = `EFT_TRIP_CFG_RES;  // [R12]
        end else if (id_lpr == 16'h0000 || id_lpr > `EFT_LPR_MAX) begin
          cfg_num = `EFT_TRIP_CFG_LPR;  // [R12]
        end
      end
    end else if (st_r == ST_ABS && (tmo_r == 16'h0000 || frm_bad)) begin
      cfg_num = `EFT_TRIP_CFG_COMMS;  // [R12]
    end
  end

  // drive reset of a tripped module restarts the interface
  wire        tripped  = trip_r | freeze_r;
  wire        reinit_w = wr_acc && avs_address == `EFT_OFS_CTRL && be1 &&
                         avs_writedata[`EFT_CTRL_REINIT];
  wire        restart  = reinit_w | (drive_reset & tripped);  // [R08]

  // link receiver: shift on each encoder clock rise inside a frame
  always @(posedge clk) begin
    if (!rst_n) begin
      eclk_d_r <= 1'b0;
      efrm_d_r <= 1'b0;
      sh_r     <= 32'h0000_0000;
      cnt_r    <= 6'h00;
    end else begin
      eclk_d_r <= eclk_s;
      efrm_d_r <= efrm_s;
      if (efrm_s && !efrm_d_r) begin
        cnt_r <= 6'h00;
      end else if (efrm_s && eclk_rise) begin
        sh_r <= {sh_r[30:0], edat_s};
        // saturate so an over-long frame still reads as bad
        if (cnt_r != 6'h3f) begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end

  // init sequencer, auto-config and position tracking
  always @(posedge clk) begin
    if (!rst_n) begin
      st_r         <= ST_IDLE;
      start_r      <= 1'b1;
      tmo_r        <= 16'h0000;
      lpr_r        <= 16'h0000;
      res_r        <= 5'h00;
      turns_bits_r <= 4'h0;
      rotary_r     <= 1'b1;
      pos_r        <= 32'h0000_0000;
      last_r       <= 16'h0000;
      pwr_ok_r     <= 1'b0;
    end else begin
      // power bit follows good position frames; identity frames carry the id there
      if (frm_ok && st_r != ST_ID) begin
        pwr_ok_r <= sh_r[31];  // [R08]
      end
      if (restart) begin
        start_r <= 1'b1;  // [R07] [R08]
      end else if (st_r == ST_IDLE) begin
        start_r <= 1'b0;
      end
      if (st_r != ST_IDLE && tmo_r != 16'h0000) begin
        tmo_r <= tmo_r - 16'h0001;
      end
      case (st_r)
        ST_IDLE: begin
          if (start_r) begin
            tmo_r <= TMO_CYC[15:0];
            // only communicating encoders are interrogated
            st_r  <= (type_r == `EFT_TYPE_SSI) ? ST_ABS : ST_ID;  // [R10]
          end
        end
        ST_ID: begin
          if (cfg_num != 5'h00) begin
            st_r <= ST_FAIL;  // [R12]
          end else if (frm_ok) begin
            if (cfg_active) begin
              turns_bits_r <= sh_r[27:24];  // [R10]
              lpr_r        <= id_lpr;       // [R10]
              res_r        <= id_res;       // [R10]
              if (type_r == `EFT_TYPE_ASYNC || type_r == `EFT_TYPE_BIDIR) begin
                rotary_r <= sh_r[2];  // [R11]
              end
            end
            tmo_r <= TMO_CYC[15:0];
            st_r  <= ST_ABS;
          end
        end
        ST_ABS: begin
          if (cfg_num != 5'h00) begin
            st_r <= ST_FAIL;
          end else if (frm_ok) begin
            // absolute start point for either tracking method
            pos_r  <= {2'b00, pos_dec};
            last_r <= pos_dec[15:0];
            st_r   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (restart) begin
            st_r <= ST_IDLE;
          end else if (frm_ok) begin
            last_r <= pos_dec[15:0];
            if (abs_dir_r) begin
              // no check on the word: a bad frame shows, the next good one heals
              pos_r <= {2'b00, pos_dec};  // [R06]
            end else begin
              // signed delta assumes under half a turn per frame; a wrong
              // turns count stays until the interface restarts
              pos_r <= pos_r + {{16{delta[15]}}, delta};  // [R07]
            end
          end
        end
        ST_FAIL: begin
          if (restart) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // trip, freeze flag and trip number; a fault in the reset cycle wins
  always @(posedge clk) begin
    if (!rst_n) begin
      trip_r     <= 1'b0;
      freeze_r   <= 1'b0;
      trip_num_r <= 5'h00;
    end else if (cfg_num != 5'h00) begin
      trip_r     <= 1'b1;  // [R12]
      trip_num_r <= cfg_num;
    end else if (run_num != 5'h00) begin
      trip_num_r <= run_num;  // [R04]
      if (suppress && run_num <= `EFT_TRIP_LAST_RUN) begin
        freeze_r <= 1'b1;  // [R02] [R04]
      end else begin
        trip_r <= 1'b1;  // [R15]
      end
    end else if (drive_reset) begin
      trip_r     <= 1'b0;   // [R15]
      freeze_r   <= 1'b0;   // [R05]
      trip_num_r <= 5'h00;  // [R05]
    end
  end

  // encoder supply cut on overload, even when the trip is suppressed
  always @(posedge clk) begin
    if (!rst_n) begin
      psu_en_r <= 1'b1;
    end else if (ovl_s) begin
      psu_en_r <= 1'b0;  // [R03]
    end else if (drive_reset) begin
      psu_en_r <= 1'b1;
    end
  end

  // events: trip raised, suppressed fault, init done, config trip
  reg         trip_d_r;
  reg         frz_d_r;
  reg  [2:0]  st_d_r;
  wire [3:0]  ev;

  always @(posedge clk) begin
    if (!rst_n) begin
      trip_d_r <= 1'b0;
      frz_d_r  <= 1'b0;
      st_d_r   <= ST_IDLE;
    end else begin
      trip_d_r <= trip_r;
      frz_d_r  <= freeze_r;
      st_d_r   <= st_r;
    end
  end

  assign ev = {(st_r == ST_FAIL) & (st_d_r != ST_FAIL),
               (st_r == ST_RUN) & (st_d_r != ST_RUN),
               freeze_r & ~frz_d_r,
               trip_r & ~trip_d_r};

  // read mux
  reg  [31:0] rmux;

  always @* begin
    rmux = 32'h0000_0000;
    if (avs_address == `EFT_OFS_CTRL) begin
      rmux[7:0] = {type_r, abs_dir_r, autocfg_r, lvl_r};
    end else if (avs_address == `EFT_OFS_STATUS) begin
      rmux[14:0] = {st_r, pwr_ok_r, psu_en_r, (st_r == ST_RUN), trip_num_r, 2'b00,
                    freeze_r, trip_r};
    end else if (avs_address == `EFT_OFS_IRQ_STAT) begin
      rmux[3:0] = irq_stat_r;
    end else if (avs_address == `EFT_OFS_IRQ_MASK) begin
      rmux[3:0] = irq_mask_r;
    end else if (avs_address == `EFT_OFS_POSITION) begin
      rmux = pos_r;
    end else if (avs_address == `EFT_OFS_AUTOCFG) begin
      rmux[28:0] = {rotary_r, turns_bits_r, 3'b000, res_r, lpr_r};
    end
  end

  // bus slave: answer phase, read capture, writes at the accept edge
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      lvl_r      <= `EFT_RST_LVL;
      autocfg_r  <= `EFT_RST_AUTOCFG;
      abs_dir_r  <= 1'b0;
      type_r     <= `EFT_RST_TYPE;
      irq_mask_r <= `EFT_RST_MASK;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read && !ack_r) begin
        rdata_r <= rmux;
      end
      if (wr_acc && be0) begin
        if (avs_address == `EFT_OFS_CTRL) begin
          lvl_r     <= avs_writedata[3:0];  // [R01]
          autocfg_r <= avs_writedata[`EFT_CTRL_AUTOCFG];
          abs_dir_r <= avs_writedata[`EFT_CTRL_ABS_DIR];
          type_r    <= avs_writedata[7:6];
        end else if (avs_address == `EFT_OFS_IRQ_MASK) begin
          irq_mask_r <= avs_writedata[3:0];
        end
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  wire [3:0] w1c = (wr_acc && be0 && avs_address == `EFT_OFS_IRQ_STAT) ?
                   avs_writedata[3:0] : 4'h0;

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= 4'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
    end
  end

  assign irq               = |(irq_stat_r & irq_mask_r);
  assign slot_trip_request = trip_r;    // [R04]
  assign freeze_position   = freeze_r;
  assign psu_enable        = psu_en_r;
endmodule

// ==== dv/eft_encoder_trip_sva.sv ====
`timescale 1ns/1ps
// port checks on bus timing, trip flags and encoder supply
module eft_encoder_trip_sva #(
  parameter TMO_CYC = 2000  // init timeout, handed on from the design
) (
  input logic        clk,
  input logic        rst_n,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        psu_overload,
  input logic        drive_reset,
  input logic        fb_selects_slot,
  input logic        slot_trip_request,
  input logic        freeze_position,
  input logic        psu_enable
);
  // one domain, so one clock and one reset for every property
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest raised with no request");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  // a trip may only drop in answer to a drive reset
  a_trip_clear: assert property ($fell(slot_trip_request) |->
    $past(drive_reset) || $past(drive_reset, 2))
    else $error("trip request dropped without drive reset");
  a_freeze_clear: assert property ($fell(freeze_position) |->
    $past(drive_reset) || $past(drive_reset, 2))
    else $error("freeze flag dropped without drive reset");
  a_freeze_only: assert property ($rose(freeze_position) |->
    !fb_selects_slot && !$rose(slot_trip_request))
    else $error("suppressed fault handled wrongly");
  // eight cycles covers the synchroniser and the output register
  a_psu_cut: assert property (psu_overload [*8] |-> !psu_enable)
    else $error("supply left on during overload");
  a_psu_latch: assert property ($rose(psu_enable) |->
    ($past(drive_reset) || $past(drive_reset, 2)) && !psu_overload)
    else $error("supply returned without drive reset");
endmodule

bind eft_encoder_trip eft_encoder_trip_sva #(.TMO_CYC(TMO_CYC)) u_sva (
  .clk               (clk),
  .rst_n             (rst_n),
  .avs_read          (avs_read),
  .avs_write         (avs_write),
  .avs_readdata      (avs_readdata),
  .avs_waitrequest   (avs_waitrequest),
  .psu_overload      (psu_overload),
  .drive_reset       (drive_reset),
  .fb_selects_slot   (fb_selects_slot),
  .slot_trip_request (slot_trip_request),
  .freeze_position   (freeze_position),
  .psu_enable        (psu_enable)
);

// ==== dv/eft_enc_model.sv ====
`timescale 1ns/1ps
// encoder end of the serial link; its clock stands still between frames
module eft_enc_model (
  output logic enc_clk,
  output logic enc_data,
  output logic enc_frame
);
  // idle link at time zero
  initial begin
    enc_clk = 1'b0;
    enc_data = 1'b0;
    enc_frame = 1'b0;
  end

  // one frame, msb first; lag makes a slow answer, n below 32 a short frame
  task automatic send(input logic [31:0] w, input int n, input int lag);
    #(lag + 3);
    enc_frame = 1'b1;
    #40;
    for (int i = 0; i < n; i++) begin
      enc_data = w[31-i];
      #40 enc_clk = 1'b1;
      #40 enc_clk = 1'b0;
    end
    #40 enc_frame = 1'b0;
    enc_data = ~enc_data;  // released line must not show the last bit
  endtask
endmodule

// ==== dv/eft_encoder_trip_test.sv ====
`timescale 1ns/1ps
// fault table, supply bit, decoding, auto-configuration, reset values
module eft_encoder_trip_test;
  localparam int          TMO  = 1000;          // shortened init timeout
  localparam logic [31:0] GOOD = 32'h8000_1234; // power good, turns 0
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        enc_clk, enc_data, enc_frame;
  logic [2:0]  flt = 3'h0;                      // wire break, phase error, overload
  logic        drive_reset = 1'b0;
  logic        fb_selects_slot = 1'b1;
  logic        slot_trip_request, freeze_position, psu_enable, irq;
  logic [31:0] rd;                              // last read data
  int          err_total = 0;
  int          samples_checked = 0;
  // level, fb select, fault pin, {0,trip,freeze,supply}, trip number
  logic [23:0] rows [10] = '{24'h010100, 24'h110501, 24'h211502, 24'h111100, 24'h900301,
                             24'h910501, 24'h012403, 24'h802203, 24'ha01302, 24'hf00301};
  // expected trip number above each identity word
  logic [39:0] bads [5] = '{40'h0c_0c1000a4, 40'h0d_3c100004, 40'h0f_3c0000a4,
                            40'h0f_3cc351a4, 40'h00_3cc350a4};

  always #5 clk = ~clk;

  eft_encoder_trip #(.TMO_CYC(TMO)) dut (
    .clk (clk), .rst_n (rst_n), .avs_address (avs_address), .avs_read (avs_read),
    .avs_write (avs_write), .avs_writedata (avs_writedata), .avs_byteenable (avs_byteenable),
    .avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest), .enc_clk (enc_clk),
    .enc_data (enc_data), .enc_frame (enc_frame), .wire_break (flt[0]),
    .phase_error (flt[1]), .psu_overload (flt[2]), .drive_reset (drive_reset),
    .fb_selects_slot (fb_selects_slot), .slot_trip_request (slot_trip_request),
    .freeze_position (freeze_position), .psu_enable (psu_enable), .irq (irq));
  eft_enc_model enc (.enc_clk (enc_clk), .enc_data (enc_data), .enc_frame (enc_frame));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one bus cycle; waitrequest and read data are taken at the same rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) chk(32'(n), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd & m, e & m);
  endtask

  task automatic frm(input logic [31:0] w, input int lag);
    enc.send(w, 32, lag);
    cyc(12);
  endtask

  task automatic dres;
    drive_reset <= 1'b1;
    cyc(1);
    drive_reset <= 1'b0;
  endtask

  task automatic outs(input logic [2:0] e);
    chk({slot_trip_request, freeze_position, psu_enable}, e);
  endtask

  // plain gray to binary, written out independently
  function automatic logic [15:0] g2b(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // main sequence
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    frm(GOOD, 0);
    foreach (rows[i]) begin
      wr(8'h00, {28'h0, rows[i][23:20]});
      fb_selects_slot <= rows[i][16];
      flt <= 3'h1 << rows[i][13:12];
      cyc(10);
      outs(rows[i][10:8]);
      rdc(8'h04, 32'h1f0, {23'h0, rows[i][4:0], 4'h0});
      flt <= 3'h0;
      cyc(8);
      dres();
      frm(GOOD, 0);
      outs(3'h1);
      rdc(8'h04, 32'h1f0, 32'h0);
    end
    $display("fault table done");
    wr(8'h08, 32'hf);
    wr(8'h00, 32'h4);
    frm(32'h0000_1234, 0);
    outs(3'h5);
    rdc(8'h04, 32'h1f0, 32'h40);
    rdc(8'h08, 32'hf, 32'h1);
    chk(irq, 1'b0);
    wr(8'h0c, 32'h1);
    cyc(1);
    chk(irq, 1'b1);
    wr(8'h08, 32'h1);
    cyc(1);
    chk(irq, 1'b0);
    dres();
    frm(32'h0000_1234, 300);
    outs(3'h5);
    dres();
    frm(GOOD, 0);
    outs(3'h5);
    dres();
    frm(GOOD, 0);
    outs(3'h1);
    $display("supply bit done");
    for (int b = 0; b < 2; b++) begin
      wr(8'h00, 32'(32'h20 | (b << 4)));
      frm(32'h8000_ffff, 0);
      frm(32'h8003_5a5a, 0);
      rdc(8'h10, 32'h3fff_ffff, b ? 32'h0003_5a5a : {g2b(16'h0003), g2b(16'h5a5a)});
    end
    // delta tracking keeps the turns count, not the frame's turns field
    wr(8'h00, 32'h10);
    frm(32'h8000_5a6a, 0);
    rdc(8'h10, 32'h3fff_ffff, 32'h0003_5a6a);
    // a cut frame while running trips with the bad-frame number
    enc.send(GOOD, 31, 0);
    cyc(12);
    outs(3'h5);
    rdc(8'h04, 32'h1f0, 32'h50);
    dres();
    frm(GOOD, 0);
    outs(3'h1);
    $display("decoding done");
    fb_selects_slot <= 1'b0;
    for (int t = 1; t < 4; t++) begin
      wr(8'h00, 32'(32'h118 | (t << 6)));
      frm(32'h3c10_00a4, t * 300);
      frm(GOOD, 0);
      rdc(8'h14, t == 3 ? 32'h0fff_ffff : 32'h1fff_ffff, 32'h1c14_1000);
      outs(3'h1);
    end
    foreach (bads[i]) begin
      dres();
      wr(8'h00, 32'h198);
      frm(bads[i][31:0], 0);
      frm(GOOD, 0);
      rdc(8'h04, 32'h1f0, {23'h0, bads[i][36:32], 4'h0});
      outs({bads[i][36:32] != 5'h0, 2'h1});
    end
    dres();
    wr(8'h00, 32'h198);
    cyc(TMO + 50);
    rdc(8'h04, 32'h1f0, 32'h70);
    outs(3'h5);
    dres();
    frm(32'h3c10_00a4, 0);
    frm(GOOD, 0);
    outs(3'h1);
    $display("auto configuration done");
    rst_n <= 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    frm(GOOD, 0);
    chk({slot_trip_request, freeze_position, psu_enable, irq}, 4'h2);
    rdc(8'h00, 32'h1ff, 32'h0);
    rdc(8'h0c, 32'hf, 32'h0);
    rdc(8'h04, 32'h5f3, 32'h400);
    wr(8'h18, 32'hffff_ffff);
    rdc(8'h18, 32'hffff_ffff, 32'h0);
    bus(1'b1, 8'h00, 32'hf, 4'h2);
    rdc(8'h00, 32'hf, 32'h0);
    $display("reset and bus done");
    finish_test();
  end

  // hang guard, far beyond the expected run length
  initial begin
    cyc(60000);
    err_total++;
    finish_test();
  end
endmodule
